// ### apmio_pkg.sv
/*
  Shared constants and types of the point-move handshake block.
  Assumes a single 100 MHz system clock; every slower rate is an enable.
*/
`default_nettype none
package apmio_pkg;

  // ****************************************************************
  // widths and depths
  // ****************************************************************
  localparam int SEL_W    = 6;   // point-select lines, point 0 to 63
  localparam int PT_DEPTH = 64;  // stored points
  localparam int POS_W    = 16;  // signed coordinate width in steps

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 10;
  localparam int STEP_PERIOD_NS = 10000;  // least time between motor steps
  localparam int STEP_CYCLES    = (STEP_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic POS_DONE_RST  = 1'b0;  // nothing finished yet after power-up
  localparam logic GRIP_DONE_RST = 1'b0;
  localparam logic ALARM_RST     = 1'b0;

  // ****************************************************************
  // sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MOVE,
    ST_ALARM
  } apmio_state_t;

endpackage
`default_nettype wire

// ### apmio_motion_if.sv
/*
  Interface between the command sequencer and the axis stepper.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface apmio_motion_if #(
  parameter int POS_W = 16
);
  logic                    load;      // one-cycle: take a new target
  logic signed [POS_W-1:0] target;    // absolute target in steps
  logic                    stop;      // level: abort and hold still
  logic                    busy;      // moving toward the target
  logic                    arrived;   // one-cycle: target reached normally
  logic signed [POS_W-1:0] position;  // present coordinate
  logic                    step;      // one-cycle motor step pulse
  logic                    dir;       // 1 = toward larger coordinates

  modport ctrl (output load, target, stop, input busy, arrived, position, step, dir);
  modport axis (input load, target, stop, output busy, arrived, position, step, dir);
endinterface
`default_nettype wire

// ### apmio_axis.sv
/*
  Axis stepper: walks the present coordinate one step per step period
  toward the loaded target and reports arrival.
  Assumes the sequencer gives a load only while the axis is not busy.
*/
`timescale 1ns/1ps
`default_nettype none
module apmio_axis
  import apmio_pkg::*;
#(
  parameter int AX_POS_W    = apmio_pkg::POS_W,
  parameter int STEP_CYC    = apmio_pkg::STEP_CYCLES
) (
  input  wire logic      clk_i,
  input  wire logic      rst_n_i,
  apmio_motion_if.axis   mif
);

  localparam int CW = $clog2(STEP_CYC + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(STEP_CYC - 1);

  generate
    if (STEP_CYC < 1 || AX_POS_W < 2) begin : g_bad
      $error("apmio_axis: step period or width out of range");
    end
  endgenerate

  logic [CW-1:0]              cnt;
  logic signed [AX_POS_W-1:0] tgt;
  logic signed [AX_POS_W-1:0] next_position;
  logic                       tick;

  // ****************************************************************
  // step-rate divider
  // ****************************************************************
  // runs only while busy so the first step comes a full period after load
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
    end else if (!mif.busy || mif.stop || cnt == CNT_LAST) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + CW'(1);
    end
  end

  assign tick = mif.busy && !mif.stop && (cnt == CNT_LAST);

  // one step toward the target
  always_comb begin
    next_position = mif.position;
    if (tgt > mif.position) begin
      next_position = mif.position + AX_POS_W'(1);
    end else if (tgt < mif.position) begin
      next_position = mif.position - AX_POS_W'(1);
    end
  end

  // ****************************************************************
  // target, coordinate and state
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tgt          <= '0;
      mif.position <= '0;
      mif.busy     <= 1'b0;
      mif.arrived  <= 1'b0;
      mif.step     <= 1'b0;
      mif.dir      <= 1'b0;
    end else begin
      mif.arrived <= 1'b0;
      mif.step    <= 1'b0;
      if (mif.stop) begin
        mif.busy <= 1'b0;  // abort: no arrival is reported
      end else if (mif.load && !mif.busy) begin
        tgt         <= mif.target;
        mif.busy    <= (mif.target != mif.position);
        mif.arrived <= (mif.target == mif.position);  // already there
        mif.dir     <= (mif.target > mif.position);
      end else if (tick) begin
        mif.position <= next_position;
        mif.step     <= 1'b1;
        if (next_position == tgt) begin
          mif.busy    <= 1'b0;
          mif.arrived <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ### apmio_core.sv
/*
  Top of the point-move handshake block: pin synchronisers, point table,
  command sequencer, done, ready and energise outputs.
  Assumes the point table is written by same-clock logic, alarm sources
  and grip-completion come from same-clock logic, and the remaining
  inputs are pins from an external controller.
*/
`timescale 1ns/1ps
`default_nettype none
module apmio_core
  import apmio_pkg::*;
#(
  parameter int CORE_POS_W = apmio_pkg::POS_W,
  parameter int STEP_CYC   = apmio_pkg::STEP_CYCLES
) (
  input  wire logic                          CLK_SYS_I,
  input  wire logic                          RSTN_I,
  input  wire logic [apmio_pkg::SEL_W-1:0]   POINT_SELECT_I,
  input  wire logic                          MOVE_START_I,
  input  wire logic                          GRIP_MODE_I,
  input  wire logic                          GRIP_DONE_EVT_I,
  input  wire logic                          ALARM_EVT_I,
  input  wire logic                          PT_WR_I,
  input  wire logic [apmio_pkg::SEL_W-1:0]   PT_IDX_I,
  input  wire logic [CORE_POS_W-1:0]         PT_VALUE_I,
  input  wire logic                          PT_REL_I,
  output logic                               POSITION_DONE_O,
  output logic                               MOVE_OR_GRIP_DONE_O,
  output logic                               READY_O,
  output logic                               MOTOR_ENERGIZE_O,
  output logic                               STEP_O,
  output logic                               DIR_O,
  output logic                               BUSY_O,
  output logic [CORE_POS_W-1:0]              POSITION_O
);

  import apmio_pkg::*;

  generate
    if (CORE_POS_W < 2 || STEP_CYC < 1) begin : g_bad
      $error("apmio_core: width or step period out of range");
    end
  endgenerate

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [SEL_W-1:0]        sel_s1;
  logic [SEL_W-1:0]        sel_s2;
  logic                    start_s1;
  logic                    start_s2;
  logic                    start_s3;
  logic                    grip_s1;
  logic                    grip_s2;
  logic                    start_evt;
  logic                    accept;
  logic [SEL_W-1:0]        point_no;
  logic [CORE_POS_W-1:0]   pt_value [PT_DEPTH];
  logic                    pt_rel   [PT_DEPTH];
  logic signed [CORE_POS_W-1:0] next_target;
  logic                    alarm;
  logic                    pos_done;
  logic                    grip_done;
  apmio_state_t            state;

  apmio_motion_if #(.POS_W(CORE_POS_W)) mif ();

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // first stage is read only by the second; edge detect uses stages 2 and 3
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sel_s1   <= '0;
      sel_s2   <= '0;
      start_s1 <= 1'b0;
      start_s2 <= 1'b0;
      start_s3 <= 1'b0;
      grip_s1  <= 1'b0;
      grip_s2  <= 1'b0;
    end else begin
      sel_s1   <= POINT_SELECT_I;
      sel_s2   <= sel_s1;
      start_s1 <= MOVE_START_I;
      start_s2 <= start_s1;
      start_s3 <= start_s2;
      grip_s1  <= GRIP_MODE_I;
      grip_s2  <= grip_s1;
    end
  end

  // a command is the rising edge of the start line
  assign start_evt = start_s2 && !start_s3;
  // commands are refused while moving or in alarm; a refused edge is dropped
  assign accept    = start_evt && (state == ST_IDLE);

  // select lines read as an unsigned number, line 0 least significant
  assign point_no  = sel_s2;

  // ****************************************************************
  // point table
  // ****************************************************************
  // flip-flop storage; a write during a move affects only later commands
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      for (int i = 0; i < PT_DEPTH; i++) begin
        pt_value[i] <= '0;
        pt_rel[i]   <= 1'b0;
      end
    end else if (PT_WR_I) begin
      pt_value[PT_IDX_I] <= PT_VALUE_I;
      pt_rel[PT_IDX_I]   <= PT_REL_I;
    end
  end

  // target of the selected point: stored coordinate or present plus amount
  always_comb begin
    if (pt_rel[point_no]) begin
      next_target = mif.position + $signed(pt_value[point_no]);
    end else begin
      next_target = $signed(pt_value[point_no]);
    end
  end

  // ****************************************************************
  // alarm latch
  // ****************************************************************
  // only the power-on reset clears it; there is no software clear on purpose
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      alarm <= ALARM_RST;
    end else if (ALARM_EVT_I) begin
      alarm <= 1'b1;
    end
  end

  // ****************************************************************
  // command sequencer
  // ****************************************************************
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (alarm || ALARM_EVT_I) begin
            state <= ST_ALARM;
          end else if (accept) begin
            state <= ST_MOVE;
          end
        end
        ST_MOVE: begin
          if (alarm || ALARM_EVT_I) begin
            state <= ST_ALARM;
          end else if (mif.arrived) begin
            state <= ST_IDLE;
          end else if (grip_s2 && GRIP_DONE_EVT_I) begin
            state <= ST_IDLE;  // gripped before the target: stop here
          end
        end
        ST_ALARM: begin
          state <= ST_ALARM;
        end
        default: begin
          state <= ST_ALARM;
        end
      endcase
    end
  end

  // axis drive: one load per accepted command unless an alarm is latched or arriving, stop on alarm or grip hold
  assign mif.load   = accept && !alarm && !ALARM_EVT_I;
  assign mif.target = next_target;
  // the raw alarm event stops the axis in its own cycle, so no step lands unreported
  assign mif.stop   = alarm || ALARM_EVT_I || (state == ST_ALARM)
                   || (state == ST_MOVE && grip_s2 && GRIP_DONE_EVT_I);

  apmio_axis #(
    .AX_POS_W (CORE_POS_W),
    .STEP_CYC (STEP_CYC)
  ) u_axis (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (RSTN_I),
    .mif     (mif)
  );

  // ****************************************************************
  // completion flags
  // ****************************************************************
  // accept and arrival never meet: accept needs idle, arrival needs a move
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pos_done <= POS_DONE_RST;
    end else if (state == ST_MOVE && mif.arrived && !alarm && !ALARM_EVT_I) begin
      pos_done <= 1'b1;
    end else if (mif.load) begin
      pos_done <= 1'b0;
    end
  end

  // grip completion only counts while gripping mode is selected
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      grip_done <= GRIP_DONE_RST;
    end else if (state == ST_MOVE && grip_s2 && GRIP_DONE_EVT_I && !alarm && !ALARM_EVT_I) begin
      grip_done <= 1'b1;
    end else if (mif.load) begin
      grip_done <= 1'b0;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // all registered so the pins never glitch on a select change
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      POSITION_DONE_O     <= 1'b0;
      MOVE_OR_GRIP_DONE_O <= 1'b0;
      READY_O             <= 1'b0;
      MOTOR_ENERGIZE_O    <= 1'b0;
      STEP_O              <= 1'b0;
      DIR_O               <= 1'b0;
      BUSY_O              <= 1'b0;
      POSITION_O          <= '0;
    end else begin
      POSITION_DONE_O     <= pos_done;
      MOVE_OR_GRIP_DONE_O <= grip_s2 ? grip_done : pos_done;
      READY_O             <= !alarm && !ALARM_EVT_I;
      MOTOR_ENERGIZE_O    <= !alarm && !ALARM_EVT_I;
      STEP_O              <= mif.step && !alarm;
      DIR_O               <= mif.dir;
      BUSY_O              <= (state == ST_MOVE);
      POSITION_O          <= mif.position;
    end
  end

endmodule
`default_nettype wire

// ### apmio_plc_model.sv
/*
  Controller-side model: drives point select, start and grip-mode pins.
  Assumes the bench pulses go_i for one cycle per command.
*/
`timescale 1ns/1ps
`default_nettype none
module apmio_plc_model (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [5:0] sel_i,
  input  wire logic       grip_i,
  output logic      [5:0] point_select_o,
  output logic            move_start_o,
  output logic            grip_mode_o
);
  // ****************
  // command pulses
  // ****************
  // select settles long before start rises, so the synced copy is stable
  initial begin
    point_select_o = 6'h00;
    move_start_o   = 1'h0;
    grip_mode_o    = 1'h0;
    forever begin
      @(posedge clk_i);
      if (go_i) begin
        #1;
        point_select_o = sel_i;
        grip_mode_o    = grip_i;
        repeat (4) @(posedge clk_i);
        #1 move_start_o = 1'h1;
        repeat (4) @(posedge clk_i);
        #1 move_start_o = 1'h0;
      end
    end
  end
endmodule
`default_nettype wire

// ### apmio_core_assertions.sv
/*
  Port checker for the point-move block.
  Assumes STEP_CYC = 4 in simulation.
*/
`timescale 1ns/1ps
`default_nettype none
module apmio_core_chk #(
  parameter int CORE_POS_W = 16
) (
  input  wire logic                  CLK_SYS_I,
  input  wire logic                  RSTN_I,
  input  wire logic                  GRIP_MODE_I,
  input  wire logic                  ALARM_EVT_I,
  input  wire logic                  POSITION_DONE_O,
  input  wire logic                  MOVE_OR_GRIP_DONE_O,
  input  wire logic                  READY_O,
  input  wire logic                  MOTOR_ENERGIZE_O,
  input  wire logic                  STEP_O,
  input  wire logic                  DIR_O,
  input  wire logic                  BUSY_O,
  input  wire logic [CORE_POS_W-1:0] POSITION_O
);
  // ****************
  // properties
  // ****************
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);
  property p_energ; READY_O == MOTOR_ENERGIZE_O; endproperty
  a_energ: assert property (p_energ) else $error("energize differs from ready");
  property p_alarm; ALARM_EVT_I |=> !READY_O && !MOTOR_ENERGIZE_O; endproperty
  a_alarm: assert property (p_alarm) else $error("alarm left ready high");
  property p_halt; ALARM_EVT_I |-> ##3 !STEP_O [*8]; endproperty
  a_halt: assert property (p_halt) else $error("steps after alarm");
  property p_latch; $fell(READY_O) |=> !READY_O [*8]; endproperty
  a_latch: assert property (p_latch) else $error("ready came back");
  property p_nobusy; $fell(READY_O) |=> !BUSY_O [*4]; endproperty
  a_nobusy: assert property (p_nobusy) else $error("busy in alarm");
  property p_stepdone; STEP_O |-> !POSITION_DONE_O; endproperty
  a_stepdone: assert property (p_stepdone) else $error("done while stepping");
  property p_rosedone; $rose(POSITION_DONE_O) |-> READY_O; endproperty
  a_rosedone: assert property (p_rosedone) else $error("done rose in alarm");
  property p_mux; !GRIP_MODE_I [*4] |-> MOVE_OR_GRIP_DONE_O == POSITION_DONE_O; endproperty
  a_mux: assert property (p_mux) else $error("combined done wrong");
  property p_poschg; $changed(POSITION_O) |-> STEP_O; endproperty
  a_poschg: assert property (p_poschg) else $error("position moved without step");
  property p_inc;
    STEP_O |-> POSITION_O == $past(POSITION_O) + {{(CORE_POS_W-1){~DIR_O}}, 1'h1};
  endproperty
  a_inc: assert property (p_inc) else $error("step size or direction wrong");
  property p_gap; STEP_O |=> !STEP_O [*3]; endproperty
  a_gap: assert property (p_gap) else $error("steps too close");
endmodule
bind apmio_core apmio_core_chk #(.CORE_POS_W(CORE_POS_W)) u_chk (
  .CLK_SYS_I(CLK_SYS_I), .RSTN_I(RSTN_I), .GRIP_MODE_I(GRIP_MODE_I),
  .ALARM_EVT_I(ALARM_EVT_I), .POSITION_DONE_O(POSITION_DONE_O),
  .MOVE_OR_GRIP_DONE_O(MOVE_OR_GRIP_DONE_O), .READY_O(READY_O),
  .MOTOR_ENERGIZE_O(MOTOR_ENERGIZE_O), .STEP_O(STEP_O), .DIR_O(DIR_O),
  .BUSY_O(BUSY_O), .POSITION_O(POSITION_O));
`default_nettype wire

// ### tb_apmio_core.sv
/*
  Self-checking bench of the point-move block with a controller model.
  Assumes STEP_CYC = 4 and a 100 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_apmio_core;
  import apmio_pkg::*;
  logic        clk = 1'h0, rstn = 1'h0, go = 1'h0, grip = 1'h0, gevt = 1'h0;
  logic        alarm = 1'h0, pt_wr = 1'h0, pt_rel = 1'h0, start, gmode;
  logic        pdone, mgdone, ready, energ, step, dir, busy;
  logic [5:0]  sel = 6'h00, pt_idx = 6'h00, psel;
  logic [15:0] pt_val = 16'h0000, position, pos = 16'h0000, tv [64];
  logic        tr [64];
  logic [31:0] seed = 32'h0001_3B36;
  int          n_fail = 0, checks_done = 0;
  // ****************
  // clock, parts
  // ****************
  always #5 clk = ~clk;
  apmio_plc_model u_plc (.clk_i(clk), .go_i(go), .sel_i(sel), .grip_i(grip),
    .point_select_o(psel), .move_start_o(start), .grip_mode_o(gmode));
  apmio_core #(.CORE_POS_W(16), .STEP_CYC(4)) u_dut (.CLK_SYS_I(clk), .RSTN_I(rstn),
    .POINT_SELECT_I(psel), .MOVE_START_I(start), .GRIP_MODE_I(gmode),
    .GRIP_DONE_EVT_I(gevt), .ALARM_EVT_I(alarm), .PT_WR_I(pt_wr), .PT_IDX_I(pt_idx),
    .PT_VALUE_I(pt_val), .PT_REL_I(pt_rel), .POSITION_DONE_O(pdone),
    .MOVE_OR_GRIP_DONE_O(mgdone), .READY_O(ready), .MOTOR_ENERGIZE_O(energ),
    .STEP_O(step), .DIR_O(dir), .BUSY_O(busy), .POSITION_O(position));
  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // relative entries add to the present spot, absolute ones replace it
  function automatic logic [15:0] nxt(logic [15:0] p, logic [15:0] v, logic r);
    return r ? p + v : v;
  endfunction
  task automatic wr(input logic [5:0] i, input logic [15:0] v, input logic r);
    tv[i] = v;
    tr[i] = r;
    pt_wr = 1'h1;
    pt_idx = i;
    pt_val = v;
    pt_rel = r;
    @(posedge clk);
    #1;
  endtask
  task automatic cmd(input logic [5:0] pt, input logic g);
    logic [15:0] e;
    e = nxt(pos, tv[pt], tr[pt]);
    sel = pt;
    grip = g;
    go = 1'h1;
    @(posedge clk);
    #1 go = 1'h0;
    repeat (10) @(posedge clk);
    #1 if (e != pos && !g) `CHK(pdone, 1'h0)
    for (int i = 0; i < 3000 && pdone !== 1'h1 && !g; i++) @(posedge clk);
    #1 if (!g) begin
      `CHK(position, e)
      `CHK(mgdone, 1'h1)
      pos = e;
    end
  endtask
  task automatic complete_run();
    if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ****************
  // watchdog
  // ****************
  initial begin
    #900000;
    n_fail++;
    complete_run();
  end
  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (6) @(posedge clk);
    #1 rstn = 1'h1;
    repeat (2) @(posedge clk);
    #1 `CHK(ready, 1'h1)
    // random table with a few pinned corner entries
    for (int i = 0; i < 64; i++) begin
      logic [31:0] r;
      r = xs();
      wr(i[5:0], {{11{r[4]}}, r[4:0]}, r[6]);
    end
    wr(6'h3E, 16'h0000, 1'h1);
    wr(6'h3F, 16'hFFE0, 1'h0);
    pt_wr = 1'h0;
    cmd(6'h3F, 1'h0);
    cmd(6'h3E, 1'h0);
    cmd(6'h00, 1'h0);
    for (int k = 0; k < 14; k++) cmd(6'(xs() % 64), 1'h0);
    // grip stops a move early: combined done rises, position done stays low
    wr(6'h05, 16'h0014, 1'h1);
    wr(6'h00, pos, 1'h0);
    pt_wr = 1'h0;
    cmd(6'h05, 1'h1);
    repeat (12) @(posedge clk);
    #1 gevt = 1'h1;
    @(posedge clk);
    #1 gevt = 1'h0;
    repeat (6) @(posedge clk);
    #1 `CHK(mgdone, 1'h1)
    `CHK(pdone, 1'h0)
    cmd(6'h00, 1'h0);
    // alarm in mid-move latches until reset
    cmd(6'h05, 1'h1);
    repeat (8) @(posedge clk);
    #1 alarm = 1'h1;
    @(posedge clk);
    #1 alarm = 1'h0;
    repeat (2) @(posedge clk);
    #1 `CHK(ready, 1'h0)
    `CHK(energ, 1'h0)
    cmd(6'h05, 1'h1);
    repeat (30) @(posedge clk);
    #1 `CHK(busy, 1'h0)
    `CHK(ready, 1'h0)
    rstn = 1'h0;
    repeat (2) @(posedge clk);
    #1 rstn = 1'h1;
    repeat (2) @(posedge clk);
    #1 `CHK(ready, 1'h1)
    complete_run();
  end
endmodule
`default_nettype wire
